// ### hdl/kass_consts.svh
// Named offsets, field positions, reset values and counts of the serial shifter.
`ifndef KASS_CONSTS_SVH
`define KASS_CONSTS_SVH
`define KASS_IDX_DATA 6'h00
`define KASS_IDX_STATUS 6'h01
`define KASS_IDX_CONTROL 6'h02
`define KASS_IDX_LINE_OUT 6'h03
`define KASS_IDX_LINE_IN 6'h04
`define KASS_IDX_IRQ_EN 6'h05
`define KASS_CON_EN 0
`define KASS_CON_XMT 1
`define KASS_CON_IDB 6:4
`define KASS_IEN_START 0
`define KASS_IEN_DONE 1
`define KASS_CON_RST 8'h00
`define KASS_OSIG_RST 8'h47
`define KASS_OSIG_CLK_RST 3'h0
`define KASS_OSIG_DAT_RST 3'h7
`define KASS_OSIG_FIXED 2'h1
`define KASS_EDGE_FIRST 4'h1
`define KASS_EDGE_LAST_DATA_RX 4'h9
`define KASS_EDGE_PARITY_RX 4'hA
`define KASS_EDGE_STOP_RX 4'hB
`define KASS_EDGE_LAST_DATA_TX 4'h8
`define KASS_EDGE_PARITY_TX 4'h9
`define KASS_EDGE_STOP_TX 4'hA
`define KASS_EDGE_LINE_CTRL 4'hB
`define KASS_DB_MAX_SEL 3'h5
`define KASS_RESP_OKAY 2'h0
`define KASS_RESP_SLVERR 2'h2
`endif

// ### hdl/kass_debounce.sv
// Debounce filter for one synchronised clock line.
`timescale 1ns/1ns
`include "kass_consts.svh"
module kass_debounce import kass_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line_in,
  input wire logic [2:0] sel,
  output logic line_out
);
  logic [5:0] cnt;
  logic [5:0] thr;
  logic [5:0] next_cnt;

  assign thr = (sel > `KASS_DB_MAX_SEL) ? (6'h01 << `KASS_DB_MAX_SEL) : (6'h01 << sel);
  assign next_cnt = cnt + 6'h01;

  // A new level is taken only after it has stood for the selected number of cycles.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 6'h00;
      line_out <= 1'b1;
    end else if (line_in == line_out) begin
      cnt <= 6'h00;
    end else if (next_cnt >= thr) begin
      cnt <= 6'h00;
      line_out <= line_in;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// ### hdl/kass_pkg.sv
// Types shared by the serial shifter modules.
package kass_pkg;
  typedef enum logic [3:0] {
    ST_DISABLED, ST_RX_INACTIVE, ST_RX_IDLE, ST_RX_ACTIVE, ST_RX_END,
    ST_TX_INACTIVE, ST_TX_IDLE, ST_TX_ACTIVE, ST_TX_END
  } kass_state_e;
  typedef logic [2:0] kass_chan_t;
endpackage

// ### hdl/kass_shifter.sv
// Three-channel device-clocked serial shift engine with an AXI4-Lite register slave.
`timescale 1ns/1ns
`include "kass_consts.svh"
module kass_shifter import kass_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [2:0] CHAN_CLK_I,
  output logic [2:0] CHAN_CLK_O,
  output logic [2:0] CHAN_CLK_OE,
  input wire logic [2:0] CHAN_DAT_I,
  output logic [2:0] CHAN_DAT_O,
  output logic [2:0] CHAN_DAT_OE,
  output logic SHIFTER_IRQ
);
  kass_state_e state;
  logic [7:0] shift_data_reg;
  logic [7:0] shifter_control_reg;
  logic [1:0] irq_enable_reg;
  kass_chan_t channel_clock_enables;
  kass_chan_t channel_data_out_bits;
  kass_chan_t active_channel_field;
  logic start_seen_flag;
  logic transfer_done_flag;
  logic parity_error_flag;
  logic frame_error_flag;
  logic [3:0] edge_cnt;
  logic [3:0] next_edge;
  logic tx_bit;
  logic [2:0] clk_meta, clk_sync, dat_meta, dat_sync;
  logic [2:0] clk_db, clk_db_q;
  logic [2:0] fall, start_vec, start_pick;
  logic act_fall, act_dat, eng_rst, any_start;
  logic [2:0] next_clk_low, next_dat_low;
  logic [7:0] status_byte;
  logic aw_full, w_full;
  logic [5:0] aw_idx;
  logic [7:0] w_byte;
  logic w_lane0;
  logic wr_fire;
  logic [5:0] ar_idx;
  logic [7:0] rd_byte;

  // Two flip-flops on every line before anything looks at it.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      clk_meta <= 3'h7;
      clk_sync <= 3'h7;
      dat_meta <= 3'h7;
      dat_sync <= 3'h7;
    end else begin
      clk_meta <= CHAN_CLK_I;
      clk_sync <= clk_meta;
      dat_meta <= CHAN_DAT_I;
      dat_sync <= dat_meta;
    end
  end

  // Only the clock lines are filtered; data is sampled at the filtered clock edge.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_db
      kass_debounce u_db (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .line_in(clk_sync[g]),
        .sel(shifter_control_reg[`KASS_CON_IDB]),
        .line_out(clk_db[g])
      );
    end
  endgenerate

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      clk_db_q <= 3'h7;
    end else begin
      clk_db_q <= clk_db;
    end
  end

  assign fall = clk_db_q & ~clk_db;
  assign start_vec = fall & ~dat_sync & channel_clock_enables;
  assign start_pick = start_vec & (~start_vec + 3'h1);
  assign any_start = |start_vec;
  assign act_fall = |(fall & active_channel_field);
  assign act_dat = |(dat_sync & active_channel_field);
  assign next_edge = edge_cnt + 4'h1;
  assign eng_rst = !shifter_control_reg[`KASS_CON_EN] || (channel_clock_enables == 3'h0);

  // Shift engine state, flags and bit counter.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_DISABLED;
      active_channel_field <= 3'h0;
      start_seen_flag <= 1'b0;
      transfer_done_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      frame_error_flag <= 1'b0;
      edge_cnt <= 4'h0;
      tx_bit <= 1'b1;
    end else if (eng_rst) begin
      active_channel_field <= 3'h0;
      start_seen_flag <= 1'b0;
      transfer_done_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      frame_error_flag <= 1'b0;
      edge_cnt <= 4'h0;
      tx_bit <= 1'b1;
      if (!shifter_control_reg[`KASS_CON_EN]) begin
        state <= ST_DISABLED;
      end else if (shifter_control_reg[`KASS_CON_XMT]) begin
        state <= ST_TX_INACTIVE;
      end else begin
        state <= ST_RX_INACTIVE;
      end
    end else begin
      unique case (state)
        ST_DISABLED: begin
          state <= ST_DISABLED;
        end
        ST_RX_INACTIVE: begin
          state <= ST_RX_IDLE;
        end
        ST_TX_INACTIVE: begin
          state <= ST_TX_IDLE;
        end
        ST_RX_IDLE: begin
          if (any_start) begin
            state <= ST_RX_ACTIVE;
            active_channel_field <= start_pick;
            start_seen_flag <= 1'b1;
            edge_cnt <= `KASS_EDGE_FIRST;
          end
        end
        ST_RX_ACTIVE: begin
          if (act_fall) begin
            edge_cnt <= next_edge;
            if (next_edge == `KASS_EDGE_PARITY_RX) begin
              parity_error_flag <= ~(^shift_data_reg ^ act_dat);
            end
            if (next_edge == `KASS_EDGE_STOP_RX) begin
              frame_error_flag <= ~act_dat;
              transfer_done_flag <= 1'b1;
              state <= ST_RX_END;
            end
          end
        end
        ST_TX_IDLE: begin
          if (any_start) begin
            state <= ST_TX_ACTIVE;
            active_channel_field <= start_pick;
            start_seen_flag <= 1'b1;
            edge_cnt <= `KASS_EDGE_FIRST;
            tx_bit <= shift_data_reg[0];
          end
        end
        ST_TX_ACTIVE: begin
          if (act_fall && edge_cnt != `KASS_EDGE_LINE_CTRL) begin
            edge_cnt <= next_edge;
            if (next_edge <= `KASS_EDGE_LAST_DATA_TX) begin
              tx_bit <= shift_data_reg[edge_cnt[2:0]];
            end else if (next_edge == `KASS_EDGE_PARITY_TX) begin
              tx_bit <= ~^shift_data_reg;
            end else begin
              tx_bit <= 1'b1;
            end
          end
          // The device answers with data low once the eleventh edge has passed.
          if (edge_cnt == `KASS_EDGE_LINE_CTRL && !act_dat) begin
            transfer_done_flag <= 1'b1;
            state <= ST_TX_END;
          end
        end
        ST_RX_END, ST_TX_END: begin
          state <= state;
        end
      endcase
    end
  end

  // Received bits enter at the top and move down, so the first one ends in bit 0.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      shift_data_reg <= 8'h00;
    end else if (!eng_rst && state == ST_RX_ACTIVE && act_fall &&
                 next_edge <= `KASS_EDGE_LAST_DATA_RX) begin
      shift_data_reg <= {act_dat, shift_data_reg[7:1]};
    end else if (wr_fire && w_lane0 && aw_idx == `KASS_IDX_DATA) begin
      shift_data_reg <= w_byte;
    end
  end

  // Software control registers; the hardware set of the data bits wins over a write.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      shifter_control_reg <= `KASS_CON_RST;
      channel_clock_enables <= `KASS_OSIG_CLK_RST;
      channel_data_out_bits <= `KASS_OSIG_DAT_RST;
      irq_enable_reg <= 2'h0;
    end else begin
      if (wr_fire && w_lane0 && aw_idx == `KASS_IDX_CONTROL) begin
        shifter_control_reg <= w_byte;
      end
      if (wr_fire && w_lane0 && aw_idx == `KASS_IDX_IRQ_EN) begin
        irq_enable_reg <= w_byte[1:0];
      end
      if (wr_fire && w_lane0 && aw_idx == `KASS_IDX_LINE_OUT) begin
        channel_clock_enables <= w_byte[5:3];
        channel_data_out_bits <= w_byte[2:0];
      end
      if (!eng_rst && state == ST_TX_IDLE && any_start) begin
        channel_data_out_bits <= 3'h7;
      end
    end
  end

  // Line drive: outside the active and end states the lines follow the control bits; the end states pull every clock low.
  always_comb begin
    next_clk_low = ~channel_clock_enables;
    next_dat_low = ~channel_data_out_bits;
    if (!eng_rst) begin
      unique case (state)
        ST_RX_ACTIVE: begin
          next_clk_low = ~active_channel_field;
        end
        ST_TX_ACTIVE: begin
          next_clk_low = ~active_channel_field;
          next_dat_low = ~channel_data_out_bits | (active_channel_field & {3{~tx_bit}});
        end
        ST_RX_END, ST_TX_END: begin
          next_clk_low = 3'h7;
        end
        ST_RX_IDLE, ST_TX_IDLE: begin
          next_clk_low = ~channel_clock_enables;
        end
        ST_DISABLED, ST_RX_INACTIVE, ST_TX_INACTIVE: begin
          next_clk_low = ~channel_clock_enables;
        end
      endcase
    end
  end

  assign CHAN_CLK_O = 3'h0;
  assign CHAN_DAT_O = 3'h0;
  assign status_byte = {1'b0, frame_error_flag, active_channel_field, parity_error_flag,
                        transfer_done_flag, start_seen_flag};

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      CHAN_CLK_OE <= 3'h0;
      CHAN_DAT_OE <= 3'h0;
      SHIFTER_IRQ <= 1'b0;
    end else begin
      CHAN_CLK_OE <= next_clk_low;
      CHAN_DAT_OE <= next_dat_low;
      SHIFTER_IRQ <= (start_seen_flag && irq_enable_reg[`KASS_IEN_START]) ||
                     (transfer_done_flag && irq_enable_reg[`KASS_IEN_DONE]);
    end
  end

  // Write channel: address and data are held until both are present.
  assign S_AXI_AWREADY = !aw_full;
  assign S_AXI_WREADY = !w_full;
  assign wr_fire = aw_full && w_full && !S_AXI_BVALID;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_idx <= 6'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `KASS_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && !aw_full) begin
        aw_full <= 1'b1;
        aw_idx <= S_AXI_AWADDR[7:2];
      end
      if (S_AXI_WVALID && !w_full) begin
        w_full <= 1'b1;
        w_byte <= S_AXI_WDATA[7:0];
        w_lane0 <= S_AXI_WSTRB[0];
      end
      if (wr_fire) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_idx > `KASS_IDX_IRQ_EN) ? `KASS_RESP_SLVERR : `KASS_RESP_OKAY;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Read channel: one outstanding read, answered the cycle after it is taken.
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign ar_idx = S_AXI_ARADDR[7:2];

  always_comb begin
    rd_byte = 8'h00;
    unique case (ar_idx)
      `KASS_IDX_DATA: rd_byte = shift_data_reg;
      `KASS_IDX_STATUS: rd_byte = status_byte;
      `KASS_IDX_CONTROL: rd_byte = shifter_control_reg;
      `KASS_IDX_LINE_OUT: rd_byte = {`KASS_OSIG_FIXED, channel_clock_enables,
                                     channel_data_out_bits};
      `KASS_IDX_LINE_IN: rd_byte = {2'h0, clk_sync, dat_sync};
      `KASS_IDX_IRQ_EN: rd_byte = {6'h00, irq_enable_reg};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= `KASS_RESP_OKAY;
    end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h00_0000, rd_byte};
      S_AXI_RRESP <= (ar_idx > `KASS_IDX_IRQ_EN) ? `KASS_RESP_SLVERR : `KASS_RESP_OKAY;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_rx_stop;
    !eng_rst && state == ST_RX_ACTIVE && act_fall && edge_cnt == `KASS_EDGE_PARITY_RX;
  endsequence
  sequence s_rx_closed;
    state == ST_RX_END && transfer_done_flag ##1 CHAN_CLK_OE == 3'h7;
  endsequence

  a_irq_start_level: assert property (
    start_seen_flag && irq_enable_reg[`KASS_IEN_START] |=> SHIFTER_IRQ)
    else $error("interrupt missing for enabled start flag");
  a_rx_inactive_entry: assert property (
    shifter_control_reg[`KASS_CON_EN] && !shifter_control_reg[`KASS_CON_XMT] &&
    channel_clock_enables == 3'h0 |=> state == ST_RX_INACTIVE)
    else $error("receive-inactive not entered");
  a_lowest_channel: assert property (
    !eng_rst && state == ST_RX_IDLE && start_vec[0] |=> active_channel_field == 3'h1)
    else $error("wrong channel chosen on simultaneous start");
  a_rx_start_flag: assert property (
    !eng_rst && state == ST_RX_IDLE && any_start |=> start_seen_flag && state == ST_RX_ACTIVE)
    else $error("receive start not recorded");
  a_rx_frame_end: assert property (
    s_rx_stop |=> s_rx_closed)
    else $error("reception did not close with clocks low");
  a_frame_error: assert property (
    (s_rx_stop and (!act_dat)) |=> frame_error_flag && state == ST_RX_END)
    else $error("low stop bit not flagged");
  a_tx_parity_bit: assert property (
    !eng_rst && state == ST_TX_ACTIVE && act_fall && edge_cnt == `KASS_EDGE_LAST_DATA_TX
    |=> tx_bit == ~^$past(shift_data_reg))
    else $error("transmit parity bit wrong");
  a_tx_start_release: assert property (
    !eng_rst && state == ST_TX_IDLE && any_start |=> channel_data_out_bits == 3'h7 ##1
    CHAN_DAT_OE == (active_channel_field & {3{~shift_data_reg[0]}}))
    else $error("transmit start did not drive bit zero");
  a_status_clear: assert property (
    eng_rst |=> status_byte == 8'h00)
    else $error("status not cleared by engine reset");
endmodule

// ### testbench/kass_dev_model.sv
// Behavioural keyboard or pointing device on the three clock and data line pairs.
`timescale 1ns/1ns
module kass_dev_model (
  input wire logic [2:0] clk_line,
  input wire logic [2:0] dat_line,
  output logic [2:0] clk_low,
  output logic [2:0] dat_low
);
  localparam int HALF_NS = 200;
  initial begin
    clk_low = 3'h0;
    dat_low = 3'h0;
  end
  // Sends one frame on each channel in mask; a channel found held low gives up and would resend.
  task automatic send_frame(input logic [2:0] mask, input logic [7:0] data, input logic bad_par,
                            input logic stop_bit);
    logic [10:0] frame;
    logic [2:0] live;
    frame = {stop_bit, (~^data) ^ bad_par, data, 1'b0};
    live = mask;
    #17;
    for (int i = 0; i < 11; i++) begin
      for (int c = 0; c < 3; c++) begin
        if (live[c]) dat_low[c] = ~frame[i];
      end
      #(HALF_NS);
      live = live & clk_line;
      dat_low = dat_low & live;
      clk_low = live;
      #(HALF_NS);
      clk_low = 3'h0;
    end
    #(HALF_NS);
    dat_low = 3'h0;
  endtask
  // Clocks a host frame in on channel c; bits are sampled late in the high phase.
  task automatic recv_frame(input int c, output logic [10:0] got, output logic ok);
    ok = 1'b0;
    got = 11'h000;
    #17;
    for (int n = 0; n < 200 && !ok; n++) begin
      #(HALF_NS / 4);
      ok = clk_line[c] & ~dat_line[c];
    end
    if (!ok) return;
    for (int k = 0; k < 11; k++) begin
      clk_low[c] = 1'b1;
      dat_low[c] = (k == 10);
      #(HALF_NS);
      clk_low[c] = 1'b0;
      #(HALF_NS - 10);
      got[k] = dat_line[c];
      #10;
    end
    dat_low[c] = 1'b0;
  endtask
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the serial shift engine and its register slave.
`timescale 1ns/1ns
`include "kass_consts.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic arvalid = 1'b0;
  logic bready = 1'b1;
  logic rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] clk_o, clk_oe, dat_o, dat_oe, dev_clk_low, dev_dat_low, clk_line, dat_line;
  int error_cnt = 0;
  int compares = 0;
  always #25 clk = ~clk;
  // Open-drain lines with pull-ups: low while any party enables a low drive.
  assign clk_line = ~((clk_oe & ~clk_o) | dev_clk_low);
  assign dat_line = ~((dat_oe & ~dat_o) | dev_dat_low);
  kass_shifter dut_u (
    .CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CHAN_CLK_I(clk_line), .CHAN_CLK_O(clk_o), .CHAN_CLK_OE(clk_oe), .CHAN_DAT_I(dat_line),
    .CHAN_DAT_O(dat_o), .CHAN_DAT_OE(dat_oe), .SHIFTER_IRQ(irq)
  );
  kass_dev_model dev_model (
    .clk_line(clk_line), .dat_line(dat_line), .clk_low(dev_clk_low), .dat_low(dev_dat_low)
  );
  task automatic tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic timeout(input string what);
    error_cnt++;
    $display("wrong value at %0t ns: %s never answered", $time, what);
    tally_and_finish();
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [31:0] resp_for(input logic [5:0] idx);
    return (idx > 6'h05) ? {30'h0, `KASS_RESP_SLVERR} : {30'h0, `KASS_RESP_OKAY};
  endfunction
  task automatic chk_pins(input logic e_irq, input logic [2:0] e_clk, input logic [2:0] e_dat,
                          input string what);
    chk({25'h0, irq, clk_oe, dat_oe}, {25'h0, e_irq, e_clk, e_dat}, what);
  endtask
  // Bready stays high throughout, so no edge ever sees it driven twice.
  task automatic wr(input logic [5:0] idx, input logic [7:0] val);
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; n < 40 && !b_ok; n++) begin
      @(posedge clk);
      if (aw_ok && w_ok && bvalid) begin
        b_ok = 1'b1;
        chk({30'h0, bresp}, resp_for(idx), "write response");
      end
      if (awready && !aw_ok) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w_ok) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (!b_ok) timeout("write");
  endtask
  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp, input string what);
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    for (int n = 0; n < 40 && !r_ok; n++) begin
      @(posedge clk);
      if (ar_ok && rvalid) begin
        r_ok = 1'b1;
        chk(rdata, {24'h00_0000, exp}, what);
        chk({30'h0, rresp}, resp_for(idx), "read response");
      end
      if (arready && !ar_ok) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
    end
    if (!r_ok) timeout("read");
  endtask
  task automatic s_reset;
    logic [7:0] rst_val [7];
    rst_val = '{8'h00, 8'h00, `KASS_CON_RST, `KASS_OSIG_RST, 8'h07, 8'h00, 8'h00};
    // The pins take their reset levels at the first edge after release, so look one edge later.
    ticks(1);
    chk_pins(1'b0, 3'h7, 3'h0, "pins after reset");
    wr(6'h06, 8'hFF);
    for (int i = 0; i < 7; i++) rd_chk(6'(i), rst_val[i], "reset value");
    wr(`KASS_IDX_LINE_OUT, 8'h7F);
    ticks(3);
    chk_pins(1'b0, 3'h0, 3'h0, "lines follow control");
    wr(`KASS_IDX_LINE_OUT, `KASS_OSIG_RST);
  endtask
  task automatic s_rx_priority;
    wr(`KASS_IDX_IRQ_EN, 8'h03);
    wr(`KASS_IDX_CONTROL, 8'h01);
    rd_chk(`KASS_IDX_STATUS, 8'h00, "inactive status");
    wr(`KASS_IDX_LINE_OUT, 8'h7F);
    ticks(4);
    chk_pins(1'b0, 3'h0, 3'h0, "receive idle");
    fork
      dev_model.send_frame(3'h3, 8'hA5, 1'b0, 1'b1);
      begin
        ticks(40);
        rd_chk(`KASS_IDX_STATUS, 8'h09, "start status");
        chk_pins(1'b1, 3'h6, 3'h0, "receive active");
      end
    join
    rd_chk(`KASS_IDX_STATUS, 8'h0B, "done status");
    rd_chk(`KASS_IDX_DATA, 8'hA5, "received byte");
    chk_pins(1'b1, 3'h7, 3'h0, "end of reception");
  endtask
  task automatic s_rx_errors;
    wr(`KASS_IDX_LINE_OUT, 8'h47);
    rd_chk(`KASS_IDX_STATUS, 8'h00, "status after abort");
    wr(`KASS_IDX_CONTROL, 8'h51);
    wr(`KASS_IDX_LINE_OUT, 8'h7F);
    dev_model.send_frame(3'h1, 8'h5A, 1'b0, 1'b1);
    rd_chk(`KASS_IDX_STATUS, 8'h00, "filtered frame");
    wr(`KASS_IDX_IRQ_EN, 8'h02);
    wr(`KASS_IDX_CONTROL, 8'h11);
    dev_model.send_frame(3'h4, 8'h5A, 1'b1, 1'b0);
    rd_chk(`KASS_IDX_STATUS, 8'h67, "error status");
    chk_pins(1'b1, 3'h7, 3'h0, "done interrupt");
    wr(`KASS_IDX_IRQ_EN, 8'h00);
    ticks(3);
    chk_pins(1'b0, 3'h7, 3'h0, "masked interrupt");
    rd_chk(`KASS_IDX_DATA, 8'h5A, "byte with errors");
  endtask
  task automatic s_tx;
    logic [7:0] b;
    logic [10:0] got;
    logic ok;
    wr(`KASS_IDX_CONTROL, 8'h00);
    ticks(3);
    rd_chk(`KASS_IDX_STATUS, 8'h00, "status after disable");
    chk_pins(1'b0, 3'h0, 3'h0, "disabled lines");
    wr(`KASS_IDX_LINE_OUT, 8'h47);
    wr(`KASS_IDX_CONTROL, 8'h03);
    ticks(3);
    chk_pins(1'b0, 3'h7, 3'h0, "transmit inactive");
    for (int i = 0; i < 2; i++) begin
      b = (i == 0) ? 8'h3C : 8'h07;
      wr(`KASS_IDX_LINE_OUT, 8'h47);
      wr(`KASS_IDX_IRQ_EN, 8'h01);
      wr(`KASS_IDX_DATA, b);
      wr(`KASS_IDX_LINE_OUT, 8'h45);
      wr(`KASS_IDX_LINE_OUT, 8'h55);
      ticks(4);
      chk_pins(1'b0, 3'h5, 3'h2, "transmit idle");
      dev_model.recv_frame(1, got, ok);
      chk({31'h0, ok}, 32'h1, "request to send");
      chk({22'h0, got[9:0]}, {22'h0, 1'b1, ~^b, b}, "sent frame");
      ticks(4);
      rd_chk(`KASS_IDX_STATUS, 8'h13, "transmit status");
      rd_chk(`KASS_IDX_LINE_OUT, 8'h57, "data bits set");
      chk_pins(1'b1, 3'h7, 3'h0, "end of transmission");
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    s_reset();
    s_rx_priority();
    s_rx_errors();
    s_tx();
    tally_and_finish();
  end
endmodule
